//--- rtl/decode_pkg.sv
// Function
// - Code register loads on class-decode byte unload
// - Code register holds through instruction execution
// - Code register drives byte bus when idle
// - Table drives low eight, microword upper six
// - Select bit chooses opcode or operand table
// - Pending higher interrupt forces operand vector FF
// - Hold-off signal suppresses the forced interrupt
// - Opcode table: function low bits pick block
// - Operand table: three function bits pick block
// - Native class decode uses block 300-3FF
// - Class table addressed by legacy flag, opcode
// - Size code stored in size register
// - Flag-update class kept in flip-flops
// - Size bit, flag class select tested condition
// - Sample condition and opcode bit at end
// - Branch-not-taken is sample xor polarity
// - Unload active on byte request or legacy
package decode_pkg;
  // Field widths
  localparam int CODE_W = 8;
  localparam int FUNC_W = 3;
  localparam int JUMP_HI_W = 6;
  localparam int NEXT_ADDR_W = 14;
  localparam int PRIO_W = 5;
  // Table geometry
  localparam int OPC_TBL_DEPTH = 1024;
  localparam int OPC_TBL_AW = 10;
  localparam int OPD_TBL_DEPTH = 512;
  localparam int OPD_TBL_AW = 9;
  localparam int OPD_BLOCK_AW = 6;
  localparam int CLS_TBL_DEPTH = 512;
  localparam int CLS_TBL_AW = 9;
  localparam int CLS_TBL_W = 4;
  localparam int TBL_WR_AW = 10;
  // Table selector on the programming port
  localparam logic [1:0] TBL_OPCODE = 2'h0;
  localparam logic [1:0] TBL_OPERAND = 2'h1;
  localparam logic [1:0] TBL_CLASS = 2'h2;
  // Decode function codes
  localparam logic [2:0] FUNC_LEGACY_CLASS = 3'h1;
  localparam logic [2:0] FUNC_NATIVE_CLASS = 3'h3;
  // Forced interrupt vector
  localparam logic [7:0] INT_VECTOR = 8'hFF;
  // Class table field positions
  localparam int CLS_FLAG_LSB = 0;
  localparam int CLS_SIZE_LSB = 2;
  // Operand size codes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_UNUSED = 2'h2;
  localparam logic [1:0] SIZE_LONG = 2'h3;
  // Flag-update classes
  localparam logic [1:0] FLAG_ADD = 2'h0;
  localparam logic [1:0] FLAG_SUB = 2'h1;
  localparam logic [1:0] FLAG_CMP = 2'h2;
  localparam logic [1:0] FLAG_LOGIC = 2'h3;
  // Reset values
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [1:0] SIZE_RESET = 2'h0;
  localparam logic [1:0] FLAG_RESET = 2'h0;
endpackage

//--- rtl/lookup_table.sv
`timescale 1ns/1ps
`default_nettype none
// Flip-flop lookup table, filled through a write port, read combinationally
module lookup_table #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic ref_clk,
  // Fill port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Lookup port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are loaded by software before use, so no reset is spent on them
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule // lookup_table
`default_nettype wire

//--- rtl/cond_select.sv
`timescale 1ns/1ps
`default_nettype none
// Picks the branch condition from the three selector bits
module cond_select (
  // Selector: size bit 0, flag class 1, flag class 0
  input wire logic [2:0] sel,
  // Current condition codes
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_v,
  input wire logic flag_c,
  // Selected condition
  output logic cond
);
  // Eight conditions
  always_comb begin
    case (sel)
      3'h0: cond = flag_z;
      3'h1: cond = flag_c | flag_z;
      3'h2: cond = flag_v;
      3'h3: cond = flag_c;
      3'h4: cond = flag_n | flag_z;
      3'h5: cond = (flag_n ^ flag_v) | flag_z;
      3'h6: cond = flag_n;
      3'h7: cond = flag_n ^ flag_v;
      default: cond = 1'b0;
    endcase
  end
endmodule // cond_select
`default_nettype wire

//--- rtl/opcode_dispatch_branch_test.sv
`timescale 1ns/1ps
`default_nettype none
// Instruction decode support: code register, dispatch tables, class logic
module opcode_dispatch_branch_test (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,

  // Instruction byte bus, two-way
  input wire logic [decode_pkg::CODE_W-1:0] instr_byte_bus_in,
  output logic [decode_pkg::CODE_W-1:0] instr_byte_bus_out,
  output logic instr_byte_bus_oe,

  // Decode micro-operation fields of the control store word
  input wire logic decode_active,
  input wire logic byte_request_bit,
  input wire logic dispatch_select_bit,
  input wire logic [decode_pkg::FUNC_W-1:0] decode_function_field,
  input wire logic [decode_pkg::JUMP_HI_W-1:0] jump_addr_hi,

  // Microsequencer jump control
  input wire logic dispatch_jump_enable,

  // Interrupt priority and hold-off
  input wire logic int_req_pending,
  input wire logic [decode_pkg::PRIO_W-1:0] int_req_level,
  input wire logic [decode_pkg::PRIO_W-1:0] cpu_priority,
  input wire logic hold_off_set,

  // Mode and condition codes
  input wire logic legacy_mode,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_v,
  input wire logic flag_c,

  // Table fill port
  input wire logic tbl_wr_en,
  input wire logic [1:0] tbl_wr_sel,
  input wire logic [decode_pkg::TBL_WR_AW-1:0] tbl_wr_addr,
  input wire logic [decode_pkg::CODE_W-1:0] tbl_wr_data,

  // Next-address bus toward the microsequencer
  output logic [decode_pkg::NEXT_ADDR_W-1:0] next_addr_bus,
  output logic next_addr_valid,
  output logic int_dispatch,

  // Status toward the data path and microsequencer
  output logic unload_active,
  output logic hold_off_interrupts,
  output logic [decode_pkg::CODE_W-1:0] instr_code_register,
  output logic [1:0] operand_size_code,
  output logic [1:0] flag_update_class,
  output logic cond_sample_ff,
  output logic polarity_bit_ff,
  output logic branch_not_taken
);

  // Instruction code register
  logic [decode_pkg::CODE_W-1:0] code_r;
  logic [decode_pkg::CODE_W-1:0] code_nxt;

  // Operand size register
  logic [1:0] size_r;
  logic [1:0] size_nxt;

  // Flag-update class flip-flops
  logic [1:0] flag_class_r;
  logic [1:0] flag_class_nxt;

  // Branch test flip-flops
  logic cond_r;
  logic cond_nxt;
  logic polarity_r;
  logic polarity_nxt;

  // Interrupt hold-off
  logic hold_off_r;
  logic hold_off_nxt;
  logic hold_off_clear;

  // Decode of the micro-operation
  logic [decode_pkg::CODE_W-1:0] ib_data;
  logic func_is_legacy;
  logic func_is_native;
  logic func_is_class;
  logic class_decode;
  logic native_class;

  // Interrupt dispatch decision
  logic int_above;
  logic force_int;
  logic use_operand_tbl;

  // Table addresses
  logic [decode_pkg::OPC_TBL_AW-1:0] opc_tbl_addr;
  logic [decode_pkg::OPD_TBL_AW-1:0] opd_tbl_addr;
  logic [decode_pkg::CLS_TBL_AW-1:0] cls_tbl_addr;

  // Table read words
  logic [decode_pkg::CODE_W-1:0] opc_tbl_data;
  logic [decode_pkg::CODE_W-1:0] opd_tbl_data;
  logic [decode_pkg::CLS_TBL_W-1:0] cls_tbl_data;

  // Class fields and branch test
  logic [1:0] cls_size;
  logic [1:0] cls_flag;
  logic [2:0] cond_sel;
  logic cond_now;

  // Low dispatch byte
  logic [decode_pkg::CODE_W-1:0] dispatch_low;

  // Table fill strobes
  logic opc_wr;
  logic opd_wr;
  logic cls_wr;

  // Unload happens on a byte request, or always in legacy mode
  // Legacy decodes never set the request bit, yet always take a byte
  assign unload_active = byte_request_bit | legacy_mode;

  // Code register owns the bus whenever nothing is being unloaded
  // Enable is the exact inverse of unload, so two sources never overlap
  assign instr_byte_bus_oe = ~unload_active;
  assign instr_byte_bus_out = code_r;

  // Internal view of the bus; avoids depending on how the wire resolves
  assign ib_data = unload_active ? instr_byte_bus_in : code_r;

  // Function codes of the two class decodes
  assign func_is_legacy = (decode_function_field == decode_pkg::FUNC_LEGACY_CLASS);
  assign func_is_native = (decode_function_field == decode_pkg::FUNC_NATIVE_CLASS);

  // Class decode recognition; without the unload term an opcode
  // decode would reload the register from its own drive
  assign func_is_class = func_is_legacy | func_is_native;
  assign class_decode = decode_active & unload_active & dispatch_select_bit &
                        func_is_class;

  // Interrupt check belongs to function-three decodes only, with either table selected
  assign native_class = decode_active & func_is_native;

  // Strictly higher priority only; an equal level waits its turn
  assign int_above = int_req_pending && (int_req_level > cpu_priority);

  // Interrupt dispatch on any function-three decode unless held off
  // Registered hold-off is used, since its set pulse comes a cycle early
  assign force_int = native_class & int_above & ~hold_off_r;

  // Table choice: select bit, overridden by the forced interrupt
  // The vector lives in the operand path, so both switch together
  assign use_operand_tbl = ~dispatch_select_bit | force_int;

  // Opcode table: two low function bits above the full byte
  // Function three lands the opcode in the 300-3FF block
  assign opc_tbl_addr = {decode_function_field[1:0], ib_data};

  // Operand table: three function bits above six byte bits
  // Only six byte bits fit; the top two are dropped on purpose
  assign opd_tbl_addr = {decode_function_field,
                         ib_data[decode_pkg::OPD_BLOCK_AW-1:0]};

  // Class table: legacy flag as the top address bit
  // Legacy opcodes reuse byte codes, so the flag keeps them apart
  assign cls_tbl_addr = {legacy_mode, ib_data};

  // Fill strobes per table
  // Selector three matches none, so such writes are dropped
  assign opc_wr = tbl_wr_en && (tbl_wr_sel == decode_pkg::TBL_OPCODE);
  assign opd_wr = tbl_wr_en && (tbl_wr_sel == decode_pkg::TBL_OPERAND);
  assign cls_wr = tbl_wr_en && (tbl_wr_sel == decode_pkg::TBL_CLASS);

  // Opcode dispatch table
  // Full fill address, all four blocks reachable
  lookup_table #(
    .WIDTH(decode_pkg::CODE_W),
    .DEPTH(decode_pkg::OPC_TBL_DEPTH),
    .AW(decode_pkg::OPC_TBL_AW)
  ) opcode_tbl (
    .ref_clk(ref_clk),
    .wr_en(opc_wr),
    .wr_addr(tbl_wr_addr),
    .wr_data(tbl_wr_data),
    .rd_addr(opc_tbl_addr),
    .rd_data(opc_tbl_data)
  );

  // Operand dispatch table
  // Fill address cut to the table depth
  lookup_table #(
    .WIDTH(decode_pkg::CODE_W),
    .DEPTH(decode_pkg::OPD_TBL_DEPTH),
    .AW(decode_pkg::OPD_TBL_AW)
  ) operand_tbl (
    .ref_clk(ref_clk),
    .wr_en(opd_wr),
    .wr_addr(tbl_wr_addr[decode_pkg::OPD_TBL_AW-1:0]),
    .wr_data(tbl_wr_data),
    .rd_addr(opd_tbl_addr),
    .rd_data(opd_tbl_data)
  );

  // Class table, four bits wide: size code above flag class
  // Upper data bits of a fill are ignored here
  lookup_table #(
    .WIDTH(decode_pkg::CLS_TBL_W),
    .DEPTH(decode_pkg::CLS_TBL_DEPTH),
    .AW(decode_pkg::CLS_TBL_AW)
  ) class_tbl (
    .ref_clk(ref_clk),
    .wr_en(cls_wr),
    .wr_addr(tbl_wr_addr[decode_pkg::CLS_TBL_AW-1:0]),
    .wr_data(tbl_wr_data[decode_pkg::CLS_TBL_W-1:0]),
    .rd_addr(cls_tbl_addr),
    .rd_data(cls_tbl_data)
  );

  // Class table fields
  // Field layout is a local choice, kept in the package
  assign cls_size = cls_tbl_data[decode_pkg::CLS_SIZE_LSB +: 2];
  assign cls_flag = cls_tbl_data[decode_pkg::CLS_FLAG_LSB +: 2];

  // Branch condition selector: size bit 0 then the flag class
  assign cond_sel = {cls_size[0], cls_flag};

  // Flags are live inputs; only the decode edge samples the result
  cond_select branch_cond (
    .sel(cond_sel),
    .flag_n(flag_n),
    .flag_z(flag_z),
    .flag_v(flag_v),
    .flag_c(flag_c),
    .cond(cond_now)
  );

  // Low dispatch byte: the vector wins over any table word
  // An interrupt overrides the word whatever the select bit says
  assign dispatch_low = force_int ? decode_pkg::INT_VECTOR :
                        (use_operand_tbl ? opd_tbl_data : opc_tbl_data);

  // Next address valid only while a jump is actually taken
  // Bus reads zero between jumps, so stale table words never leak
  assign next_addr_valid = decode_active & dispatch_jump_enable;
  assign next_addr_bus = next_addr_valid ? {jump_addr_hi, dispatch_low} :
                         '0;

  // Marks the forced dispatch for the microsequencer
  assign int_dispatch = next_addr_valid & force_int;

  // Code register: loads only on a class decode, otherwise holds
  // Raw bus is the source, as only the buffer drives it during an unload
  assign code_nxt = class_decode ? instr_byte_bus_in : code_r;

  // Size and flag class captured with the opcode
  // Both come from one table word, so they cannot disagree
  assign size_nxt = class_decode ? cls_size : size_r;
  assign flag_class_nxt = class_decode ? cls_flag : flag_class_r;

  // Branch test state sampled at the end of the class decode
  assign cond_nxt = class_decode ? cond_now : cond_r;
  assign polarity_nxt = class_decode ? ib_data[0] : polarity_r;

  // Hold-off is used up by the decode that follows it
  assign hold_off_clear = hold_off_r & decode_active;

  // Hold-off lasts from the preceding micro-op through the decode;
  // a set in the same cycle as a decode ending wins
  assign hold_off_nxt = hold_off_set | (hold_off_r & ~hold_off_clear);

  // Code register
  // Reset value is arbitrary; the first class decode overwrites it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      code_r <= decode_pkg::CODE_RESET;
    end else begin
      code_r <= code_nxt;
    end
  end

  // Size register
  // Read by the data path through the whole instruction
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      size_r <= decode_pkg::SIZE_RESET;
    end else begin
      size_r <= size_nxt;
    end
  end

  // Flag class flip-flops
  // Held here so the table output may change after the decode
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag_class_r <= decode_pkg::FLAG_RESET;
    end else begin
      flag_class_r <= flag_class_nxt;
    end
  end

  // Condition sample flip-flop
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cond_r <= 1'b0;
    end else begin
      cond_r <= cond_nxt;
    end
  end

  // Polarity flip-flop; the opcode low bit picks the branch sense
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      polarity_r <= 1'b0;
    end else begin
      polarity_r <= polarity_nxt;
    end
  end

  // Interrupt hold-off
  // Only the register reaches the interrupt logic
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hold_off_r <= 1'b0;
    end else begin
      hold_off_r <= hold_off_nxt;
    end
  end

  // Decode results from flip-flops
  assign instr_code_register = code_r;
  assign operand_size_code = size_r;
  assign flag_update_class = flag_class_r;

  // Branch test flip-flops
  assign cond_sample_ff = cond_r;
  assign polarity_bit_ff = polarity_r;

  // Hold-off state for the microsequencer
  assign hold_off_interrupts = hold_off_r;

  // Low when the branch condition matches the opcode polarity
  // Xor of two flops only, so it settles cleanly after the edge
  assign branch_not_taken = cond_r ^ polarity_r;

endmodule // opcode_dispatch_branch_test
`default_nettype wire

//--- verification/decode_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the decode block
module decode_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Inputs watched
  input wire logic [7:0] instr_byte_bus_in,
  input wire logic decode_active,
  input wire logic byte_request_bit,
  input wire logic dispatch_select_bit,
  input wire logic [2:0] decode_function_field,
  input wire logic [5:0] jump_addr_hi,
  input wire logic dispatch_jump_enable,
  input wire logic int_req_pending,
  input wire logic [4:0] int_req_level,
  input wire logic [4:0] cpu_priority,
  input wire logic legacy_mode,
  // Outputs watched
  input wire logic [7:0] instr_byte_bus_out,
  input wire logic instr_byte_bus_oe,
  input wire logic [13:0] next_addr_bus,
  input wire logic next_addr_valid,
  input wire logic int_dispatch,
  input wire logic unload_active,
  input wire logic hold_off_interrupts,
  input wire logic [7:0] instr_code_register,
  input wire logic polarity_bit_ff,
  input wire logic cond_sample_ff,
  input wire logic branch_not_taken
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Class decode is function 1 or 3 with opcode table and unload
  wire cls = decode_active & unload_active & dispatch_select_bit & (decode_function_field[0]
    & ~decode_function_field[2]);
  wire frc = next_addr_valid & (decode_function_field == 3'h3) & int_req_pending
    & (int_req_level > cpu_priority) & ~hold_off_interrupts;
  property p_oe; instr_byte_bus_oe == !unload_active && instr_byte_bus_out == instr_code_register; endproperty
  a_oe: assert property (p_oe) else $error("byte bus drive wrong");
  property p_unl; unload_active == (byte_request_bit | legacy_mode); endproperty
  a_unl: assert property (p_unl) else $error("unload flag wrong");
  property p_load; cls |=> instr_code_register == $past(instr_byte_bus_in); endproperty
  a_load: assert property (p_load) else $error("code not loaded");
  property p_hold; !cls |=> $stable(instr_code_register); endproperty
  a_hold: assert property (p_hold) else $error("code changed");
  property p_hi; next_addr_valid |-> next_addr_bus[13:8] == jump_addr_hi; endproperty
  a_hi: assert property (p_hi) else $error("upper jump bits wrong");
  property p_val; next_addr_valid == (decode_active & dispatch_jump_enable); endproperty
  a_val: assert property (p_val) else $error("jump valid wrong");
  property p_frc; frc |-> int_dispatch && next_addr_bus[7:0] == 8'hFF; endproperty
  a_frc: assert property (p_frc) else $error("vector not forced");
  property p_mask; hold_off_interrupts |-> !int_dispatch; endproperty
  a_mask: assert property (p_mask) else $error("forced while held off");
  property p_pol; cls |=> polarity_bit_ff == $past(instr_byte_bus_in[0]); endproperty
  a_pol: assert property (p_pol) else $error("polarity not sampled");
  property p_bnt; branch_not_taken == (cond_sample_ff ^ polarity_bit_ff); endproperty
  a_bnt: assert property (p_bnt) else $error("branch result wrong");
  // Main scenarios reached
  c_cls: cover property (cls ##1 !branch_not_taken);
  c_int: cover property (int_dispatch);
  c_opc: cover property (next_addr_valid && !unload_active);
endmodule // decode_checker
`default_nettype wire

//--- verification/byte_source.sv
`timescale 1ns/1ps
`default_nettype none
// Far side of the byte bus: prefetch buffer byte while unloading
module byte_source (
  // Clock
  input wire logic ref_clk,
  // Drive controls
  input wire logic oe,
  input wire logic unload,
  input wire logic [7:0] drv,
  input wire logic [7:0] pfr_byte,
  // Resolved bus
  output logic [7:0] bus
);
  logic [7:0] last_r = 8'h00;
  // Nobody driving shows a changing pattern, never a stale byte
  always_ff @(posedge ref_clk) last_r <= bus;
  assign bus = unload ? pfr_byte : (oe ? drv : ~last_r);
endmodule // byte_source
`default_nettype wire

//--- verification/opcode_dispatch_branch_test_test.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the decode block
module opcode_dispatch_branch_test_test;
  // Design pins
  logic ref_clk = 0;
  logic reset = 1;
  logic [7:0] instr_byte_bus_in, instr_byte_bus_out, instr_code_register, pfr_byte = '0;
  logic instr_byte_bus_oe, next_addr_valid, int_dispatch, unload_active, hold_off_interrupts;
  logic cond_sample_ff, polarity_bit_ff, branch_not_taken;
  logic [13:0] next_addr_bus;
  logic [1:0] operand_size_code, flag_update_class, tbl_wr_sel = '0;
  logic decode_active = 0, byte_request_bit = 0, dispatch_select_bit = 0;
  logic dispatch_jump_enable = 0, int_req_pending = 0, hold_off_set = 0, legacy_mode = 0;
  logic tbl_wr_en = 0, flag_n = 0, flag_z = 0, flag_v = 0, flag_c = 0;
  logic [2:0] decode_function_field = '0;
  logic [5:0] jump_addr_hi = '0;
  logic [4:0] int_req_level = '0, cpu_priority = '0;
  logic [9:0] tbl_wr_addr = '0;
  logic [7:0] tbl_wr_data = '0;
  logic [14:0] exp_st;
  int num_errors = 0, total_checks = 0;
  wire logic [14:0] st = {instr_code_register, operand_size_code, flag_update_class,
    cond_sample_ff, polarity_bit_ff, branch_not_taken};
  always #2 ref_clk = ~ref_clk;
  opcode_dispatch_branch_test dut (.ref_clk, .reset, .instr_byte_bus_in, .instr_byte_bus_out,
    .instr_byte_bus_oe, .decode_active, .byte_request_bit, .dispatch_select_bit,
    .decode_function_field, .jump_addr_hi, .dispatch_jump_enable, .int_req_pending,
    .int_req_level, .cpu_priority, .hold_off_set, .legacy_mode, .flag_n, .flag_z, .flag_v,
    .flag_c, .tbl_wr_en, .tbl_wr_sel, .tbl_wr_addr, .tbl_wr_data, .next_addr_bus,
    .next_addr_valid, .int_dispatch, .unload_active, .hold_off_interrupts, .instr_code_register,
    .operand_size_code, .flag_update_class, .cond_sample_ff, .polarity_bit_ff, .branch_not_taken);
  byte_source far_end (.ref_clk, .oe(instr_byte_bus_oe), .unload(unload_active),
    .drv(instr_byte_bus_out), .pfr_byte, .bus(instr_byte_bus_in));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One table word; the strobe drops for a cycle so drivers never overlap
  task wr(input logic [1:0] s, input logic [9:0] a, input logic [7:0] d);
    tbl_wr_en = 1;
    tbl_wr_sel = s;
    tbl_wr_addr = a;
    tbl_wr_data = d;
    @(posedge ref_clk);
    #1;
    tbl_wr_en = 0;
    @(posedge ref_clk);
    #1;
  endtask
  task go(input logic [2:0] f, input logic s, input logic r);
    decode_active = 1;
    decode_function_field = f;
    dispatch_select_bit = s;
    byte_request_bit = r;
    dispatch_jump_enable = 1;
    jump_addr_hi = {3'h5, f};
    #2;
  endtask
  // Ends a decode; an idle edge keeps the next request out of this time step
  task fin;
    @(posedge ref_clk);
    #1;
    decode_active = 0;
    dispatch_jump_enable = 0;
    byte_request_bit = 0;
    @(posedge ref_clk);
    #1;
  endtask
  // Condition per selector, f is {n,z,v,c}
  function automatic logic cexp(input logic [2:0] s, input logic [3:0] f);
    logic [7:0] t;
    t = {f[3] ^ f[1], f[3], (f[3] ^ f[1]) | f[2], f[3] | f[2], f[0], f[1], f[0] | f[2], f[2]};
    return t[s];
  endfunction
  task automatic t_dispatch;
    for (int f = 0; f < 8; f++) begin
      wr(2'h1, {1'b0, f[2:0], 6'h27}, {f[2:0], 5'h11});
      if (f < 4) wr(2'h0, {f[1:0], 8'hA7}, {f[2:0], 5'h0C});
    end
    wr(2'h3, 10'h0A7, 8'hEE);
    pfr_byte = 8'hA7;
    for (int f = 0; f < 8; f++) begin
      go(f[2:0], 1'b0, 1'b1);
      chk(next_addr_bus, {3'h5, f[2:0], f[2:0], 5'h11});
      fin;
      if (f < 4) begin
        go(f[2:0], 1'b1, 1'b1);
        chk(next_addr_bus, {3'h5, f[2:0], f[2:0], 5'h0C});
        fin;
      end
    end
    // Decode with no jump taken: not valid, bus at zero
    decode_active = 1;
    byte_request_bit = 1;
    #2;
    chk({next_addr_valid, next_addr_bus}, 16'h0000);
    fin;
  endtask
  task automatic t_class;
    logic [7:0] op;
    logic [3:0] fl;
    logic ce;
    for (int i = 0; i < 8; i++) begin
      op = 8'h12 | i[0];
      fl = 4'(i * 5 + 3);
      ce = cexp(i[2:0], fl);
      wr(2'h2, {2'h0, op}, {4'h0, i[0], i[2], i[1:0]});
      {flag_n, flag_z, flag_v, flag_c} = fl;
      pfr_byte = op;
      go(3'h3, 1'b1, 1'b1);
      fin;
      exp_st = {op, i[0], i[2], i[1:0], ce, op[0], ce ^ op[0]};
      chk(st, exp_st);
    end
  endtask
  task t_hold;
    wr(2'h0, {2'h2, 8'h13}, 8'hC3);
    pfr_byte = 8'h5A;
    go(3'h2, 1'b1, 1'b0);
    chk({instr_byte_bus_oe, next_addr_bus}, {1'b1, 3'h5, 3'h2, 8'hC3});
    fin;
    go(3'h1, 1'b0, 1'b1);
    fin;
    chk(st, exp_st);
  endtask
  task t_legacy;
    wr(2'h2, 10'h113, 8'h0E);
    legacy_mode = 1;
    pfr_byte = 8'h13;
    go(3'h1, 1'b1, 1'b0);
    chk(unload_active, 1'b1);
    fin;
    chk(st[6:3], 4'hE);
    legacy_mode = 0;
  endtask
  task t_int;
    wr(2'h0, {2'h3, 8'h55}, 8'h3C);
    pfr_byte = 8'h55;
    int_req_pending = 1;
    int_req_level = 5'h0A;
    cpu_priority = 5'h09;
    go(3'h3, 1'b1, 1'b1);
    chk({int_dispatch, next_addr_bus}, {1'b1, 6'h2B, 8'hFF});
    fin;
    cpu_priority = 5'h0A;
    go(3'h3, 1'b1, 1'b1);
    chk({int_dispatch, next_addr_bus}, {1'b0, 6'h2B, 8'h3C});
    fin;
    cpu_priority = 5'h09;
    hold_off_set = 1;
    @(posedge ref_clk);
    #1;
    hold_off_set = 0;
    chk(hold_off_interrupts, 1'b1);
    go(3'h3, 1'b1, 1'b1);
    chk({int_dispatch, next_addr_bus}, {1'b0, 6'h2B, 8'h3C});
    fin;
    int_req_pending = 0;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    reset = 0;
    chk({instr_byte_bus_oe, st}, 16'h8000);
    t_dispatch;
    t_class;
    t_hold;
    t_legacy;
    t_int;
    end_of_test;
  end
  // Watchdog, far beyond the hundred or so cycles needed
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule // opcode_dispatch_branch_test_test
bind opcode_dispatch_branch_test decode_checker u_chk (.ref_clk, .reset, .instr_byte_bus_in,
  .decode_active, .byte_request_bit, .dispatch_select_bit, .decode_function_field,
  .jump_addr_hi, .dispatch_jump_enable, .int_req_pending, .int_req_level, .cpu_priority,
  .legacy_mode, .instr_byte_bus_out, .instr_byte_bus_oe, .next_addr_bus, .next_addr_valid,
  .int_dispatch, .unload_active, .hold_off_interrupts, .instr_code_register, .polarity_bit_ff,
  .cond_sample_ff, .branch_not_taken);
`default_nettype wire
